/* design/dim_input_pkg.sv */
package dim_input_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES_DEF = (MS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRE_W = 17;
  localparam int MS_W = 14;
  typedef logic [MS_W-1:0] ms_t;

  localparam ms_t DEB_30_MS = 14'h001e;
  localparam ms_t DEB_50_MS = 14'h0032;
  localparam ms_t DEB_80_MS = 14'h0050;
  localparam ms_t DEB_100_MS = 14'h0064;
  localparam ms_t DEB_200_MS = 14'h00c8;
  localparam ms_t DEB_1_S = 14'h03e8;
  localparam ms_t DEB_5_S = 14'h1388;
  localparam ms_t DEB_10_S = 14'h2710;
  localparam ms_t PRESS_BASE_MS = 14'h012c;
  localparam ms_t PRESS_STEP_MS = 14'h0064;
  localparam ms_t RESTORE_5_S = 14'h1388;
  localparam ms_t RESTORE_10_S = 14'h2710;
  localparam ms_t RESTORE_15_S = 14'h3a98;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_BLOCK = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_LASTCMD = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int F_ACT = 0;
  localparam int F_FN = 1;
  localparam int F_DEB = 3;
  localparam int F_LONG = 6;
  localparam int F_DCEN = 9;
  localparam int F_DCT = 10;
  localparam int F_BLKEN = 13;
  localparam int F_BLKINV = 14;
  localparam int F_VAR = 15;
  localparam int F_INC = 18;
  localparam int F_RST = 21;
  localparam int F_BSET = 25;
  localparam int F_BCAN = 27;
  localparam logic [31:0] CTRL_RESET = 32'h0000_000d;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [1:0] FN_DIMMING = 2'h2;
  localparam logic [2:0] VAR_ONE = 3'h0;
  localparam logic [2:0] VAR_BRIGHT_ON = 3'h1;
  localparam logic [2:0] VAR_BRIGHT_TOG = 3'h2;
  localparam logic [2:0] VAR_DARK_OFF = 3'h3;
  localparam logic [2:0] VAR_DARK_TOG = 3'h4;
  localparam logic [1:0] BSET_IGNORE = 2'h0;
  localparam logic [1:0] BSET_ON = 2'h2;
  localparam logic [1:0] BSET_OFF = 2'h3;
  localparam logic [1:0] BCAN_ON = 2'h1;
  localparam logic [1:0] BCAN_OFF = 2'h2;
  localparam logic [2:0] STEP_STOP = 3'h0;
  localparam logic [2:0] STEP_MAX_CODE = 3'h7;

  typedef enum logic [2:0] {ST_IDLE, ST_PRESS, ST_LONG, ST_WAIT2, ST_SECOND} fsm_e;

  function automatic ms_t deb_ms(input logic [2:0] sel);
    case (sel)
      3'h0: deb_ms = DEB_30_MS;
      3'h1: deb_ms = DEB_50_MS;
      3'h2: deb_ms = DEB_80_MS;
      3'h3: deb_ms = DEB_100_MS;
      3'h4: deb_ms = DEB_200_MS;
      3'h5: deb_ms = DEB_1_S;
      3'h6: deb_ms = DEB_5_S;
      default: deb_ms = DEB_10_S;
    endcase
  endfunction

  // 300 ms .. 1 s in 100 ms steps
  function automatic ms_t press_ms(input logic [2:0] sel);
    press_ms = PRESS_BASE_MS + ms_t'(PRESS_STEP_MS * sel);
  endfunction

endpackage

/* design/debounce_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface debounce_if;
  import dim_input_pkg::*;
  logic raw;
  logic stable;
  logic ms_tick;
  ms_t deb_ms;
  modport filt (input raw, input deb_ms, output stable, output ms_tick);
  modport user (output raw, output deb_ms, input stable, input ms_tick);
endinterface
`default_nettype wire

/* design/contact_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
module contact_debounce import dim_input_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  debounce_if.filt dif
);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic tick;
    logic stable;
    ms_t cnt;
  } deb_s;

  deb_s s_q;
  deb_s s_d;

  // ----------------------------------------------------------------
  // millisecond base and stability counter
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.pre == PRE_W'(MS_CYCLES - 1)) begin
      s_d.pre = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + 1'b1;
    end
    if (dif.raw == s_q.stable) begin
      s_d.cnt = '0;
    end else if (s_q.tick) begin
      // level only taken once it held through deb_ms ticks of the ms base, the first of which may come early
      if (s_q.cnt + 1'b1 >= dif.deb_ms) begin
        s_d.stable = dif.raw;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign dif.stable = s_q.stable;
  assign dif.ms_tick = s_q.tick;

endmodule
`default_nettype wire

/* design/pushbutton_dimming_input.sv */
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pushbutton_dimming_input import dim_input_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic button_in,
  input wire logic bus_restored,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cmd_valid,
  output logic cmd_switch,
  output logic cmd_on,
  output logic cmd_up,
  output logic [2:0] cmd_step,
  output logic dclick_pulse,
  output logic toggle_state,
  output logic blocked
);

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic block_val;
    fsm_e st;
    ms_t tmr;
    logic last_up;
    logic toggle;
    logic blocked;
    logic rst_pend;
    logic rst_on;
    ms_t rst_lim;
    ms_t rst_tmr;
    logic cmd_valid;
    logic cmd_switch;
    logic cmd_on;
    logic cmd_up;
    logic [2:0] cmd_step;
    logic dclick;
  } top_s;

  top_s s_q, s_d;
  debounce_if dif ();
  contact_debounce #(.MS_CYCLES(MS_CYCLES)) u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .dif(dif)
  );
  assign dif.raw = button_in;
  assign dif.deb_ms = deb_ms(s_q.ctrl[F_DEB +: 3]);

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  logic chan_on, blk_want;
  logic [2:0] variant, step_code;
  logic [1:0] bset, bcan;
  logic [3:0] rst_code;
  assign chan_on = s_q.ctrl[F_ACT] && (s_q.ctrl[F_FN +: 2] == FN_DIMMING);
  assign variant = s_q.ctrl[F_VAR +: 3];
  assign bset = s_q.ctrl[F_BSET +: 2];
  assign bcan = s_q.ctrl[F_BCAN +: 2];
  assign rst_code = s_q.ctrl[F_RST +: 4];
  // field value n gives step code n+1, capped at 7; release then sends the stop
  assign step_code = (s_q.ctrl[F_INC +: 3] >= STEP_MAX_CODE) ? STEP_MAX_CODE
                     : s_q.ctrl[F_INC +: 3] + 3'h1;
  // an ignored block never blocks, so the cancel action cannot follow either
  assign blk_want = s_q.ctrl[F_BLKEN]
                    && (s_q.block_val ^ s_q.ctrl[F_BLKINV])
                    && (bset != BSET_IGNORE);
  // ready only while state advances, so nothing is taken and lost
  assign s_axi_awready = ce && !s_q.aw_held;
  assign s_axi_wready = ce && !s_q.w_held;
  assign s_axi_arready = ce && !s_q.rvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ev, ev_sw, ev_on, ev_up, short_ev, long_ev, stop_ev, short_on, long_up;
    logic [2:0] ev_step;
    ev = 1'b0;
    ev_sw = 1'b0;
    ev_on = 1'b0;
    ev_up = 1'b0;
    ev_step = STEP_STOP;
    short_ev = 1'b0;
    long_ev = 1'b0;
    stop_ev = 1'b0;
    short_on = 1'b0;
    long_up = 1'b0;
    s_d = s_q;
    s_d.cmd_valid = 1'b0;
    s_d.dclick = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.awaddr)
        OFF_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            if (s_q.wstrb[i]) begin
              s_d.ctrl[8*i +: 8] = s_q.wdata[8*i +: 8];
            end
          end
        end
        OFF_BLOCK: begin
          if (s_q.wstrb[0]) begin
            s_d.block_val = s_q.wdata[0];
          end
        end
        OFF_STATUS, OFF_LASTCMD: ;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: s_d.rdata = s_q.ctrl;
        OFF_BLOCK: s_d.rdata = {31'h0000_0000, s_q.block_val};
        OFF_STATUS: s_d.rdata = {25'h000_0000, s_q.st, s_q.rst_pend, s_q.toggle, s_q.blocked, dif.stable};
        OFF_LASTCMD: s_d.rdata = {26'h000_0000, s_q.cmd_step, s_q.cmd_up, s_q.cmd_on, s_q.cmd_switch};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (dif.ms_tick && (s_q.tmr != '1)) begin
      s_d.tmr = s_q.tmr + 1'b1;
    end
    if (!chan_on || s_q.blocked) begin
      // blocked: no press becomes a command and nothing repeats
      s_d.st = ST_IDLE;
    end else begin
      case (s_q.st)
        ST_IDLE: begin
          if (dif.stable) begin
            s_d.st = ST_PRESS;
            s_d.tmr = '0;
          end
        end
        ST_PRESS: begin
          if (!dif.stable) begin
            if (s_q.ctrl[F_DCEN]) begin
              s_d.st = ST_WAIT2;
              s_d.tmr = '0;
            end else begin
              short_ev = 1'b1;
              s_d.st = ST_IDLE;
            end
          end else if (s_q.tmr >= press_ms(s_q.ctrl[F_LONG +: 3])) begin
            long_ev = 1'b1;
            s_d.st = ST_LONG;
          end
        end
        ST_LONG: begin
          if (!dif.stable) begin
            stop_ev = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
        ST_WAIT2: begin
          if (dif.stable) begin
            s_d.dclick = 1'b1;
            s_d.st = ST_SECOND;
          end else if (s_q.tmr >= press_ms(s_q.ctrl[F_DCT +: 3])) begin
            // window over: the first press stands as a single click
            short_ev = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
        ST_SECOND: begin
          if (!dif.stable) begin
            s_d.st = ST_IDLE;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    case (variant)
      VAR_BRIGHT_ON: begin
        short_on = 1'b1;
        long_up = 1'b1;
      end
      VAR_BRIGHT_TOG: begin
        short_on = !s_q.toggle;
        long_up = 1'b1;
      end
      VAR_DARK_OFF: begin
        short_on = 1'b0;
        long_up = 1'b0;
      end
      VAR_DARK_TOG: begin
        short_on = !s_q.toggle;
        long_up = 1'b0;
      end
      default: begin
        short_on = !s_q.toggle;
        long_up = !s_q.last_up;
      end
    endcase
    if (short_ev) begin
      ev = 1'b1;
      ev_sw = 1'b1;
      ev_on = short_on;
    end
    if (long_ev) begin
      ev = 1'b1;
      ev_up = long_up;
      ev_step = step_code;
      s_d.last_up = long_up;
    end
    if (stop_ev) begin
      ev = 1'b1;
      ev_up = s_q.last_up;
      ev_step = STEP_STOP;
    end
    if (s_q.rst_pend && dif.ms_tick) begin
      s_d.rst_tmr = s_q.rst_tmr + 1'b1;
    end
    if (s_q.rst_pend && (s_q.rst_tmr >= s_q.rst_lim)) begin
      s_d.rst_pend = 1'b0;
      ev = 1'b1;
      ev_sw = 1'b1;
      ev_on = s_q.rst_on;
    end
    if (bus_restored) begin
      s_d.rst_tmr = '0;
      s_d.rst_pend = 1'b0;
      case (rst_code)
        4'h1, 4'h2: begin
          ev = 1'b1;
          ev_sw = 1'b1;
          ev_on = (rst_code == 4'h1);
        end
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
          s_d.rst_pend = 1'b1;
          s_d.rst_on = (rst_code <= 4'h5);
          case (rst_code)
            4'h3, 4'h6: s_d.rst_lim = RESTORE_5_S;
            4'h4, 4'h7: s_d.rst_lim = RESTORE_10_S;
            default: s_d.rst_lim = RESTORE_15_S;
          endcase
        end
        default: ;
      endcase
    end
    // block set and cancel take precedence over everything else
    s_d.blocked = blk_want;
    if (blk_want && !s_q.blocked && (bset == BSET_ON || bset == BSET_OFF)) begin
      ev = 1'b1;
      ev_sw = 1'b1;
      ev_on = (bset == BSET_ON);
    end
    if (!blk_want && s_q.blocked && (bcan == BCAN_ON || bcan == BCAN_OFF)) begin
      ev = 1'b1;
      ev_sw = 1'b1;
      ev_on = (bcan == BCAN_ON);
    end
    // an inactive or non-dimming channel sends nothing at all
    if (ev && chan_on) begin
      s_d.cmd_valid = 1'b1;
      s_d.cmd_switch = ev_sw;
      s_d.cmd_on = ev_on;
      s_d.cmd_up = ev_up;
      s_d.cmd_step = ev_step;
      // assumed dimmer state follows what was last sent
      if (ev_sw) begin
        s_d.toggle = ev_on;
      end else if (ev_up && (ev_step != STEP_STOP)) begin
        s_d.toggle = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.st <= ST_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign cmd_valid = s_q.cmd_valid;
  assign cmd_switch = s_q.cmd_switch;
  assign cmd_on = s_q.cmd_on;
  assign cmd_up = s_q.cmd_up;
  assign cmd_step = s_q.cmd_step;
  assign dclick_pulse = s_q.dclick;
  assign toggle_state = s_q.toggle;
  assign blocked = s_q.blocked;

endmodule
`default_nettype wire

/* tb/dim_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module dim_partner (
  input wire logic aclk,
  input wire logic press,
  output logic button_in,
  input wire logic cmd_valid,
  input wire logic cmd_switch,
  input wire logic cmd_on,
  input wire logic cmd_up,
  input wire logic [2:0] cmd_step,
  output logic [15:0] n_cmd,
  output logic [5:0] last_cmd
);
  logic lvl = 1'b0;
  logic [3:0] bnc = 4'h0;
  initial n_cmd = 16'h0;
  initial last_cmd = 6'h0;
  // contact chatters for a few cycles on every change
  assign button_in = (bnc != 4'h0) ? bnc[1] : lvl;
  always @(posedge aclk) begin
    if (press != lvl) begin
      lvl <= press;
      bnc <= 4'hf;
    end else if (bnc != 4'h0) begin
      bnc <= bnc - 4'h1;
    end
    // unused fields are masked: they read as zero, not as the previous command
    if (cmd_valid) begin
      n_cmd <= n_cmd + 16'h1;
      last_cmd <= cmd_switch ? {1'b1, cmd_on, 4'h0} : {2'b00, cmd_up, cmd_step};
    end
  end
endmodule
`default_nettype wire

/* tb/dim_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dim_checker import dim_input_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic button_in,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic cmd_valid,
  input wire logic cmd_switch,
  input wire logic cmd_on,
  input wire logic cmd_up,
  input wire logic [2:0] cmd_step,
  input wire logic dclick_pulse,
  input wire logic toggle_state,
  input wire logic blocked
);
  // one tick of slack: the ms time base may fire early
  localparam int LOW_MIN = (30 - 1) * MS_CYCLES;
  logic [23:0] low_q;
  logic dir_q;
  wire logic dim_go = cmd_valid && !cmd_switch && cmd_step != 3'h0;
  wire logic dim_stop = cmd_valid && !cmd_switch && cmd_step == 3'h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || button_in) begin
      low_q <= 24'h0;
    end else if (low_q != 24'hffffff) begin
      low_q <= low_q + 24'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 1'b0;
    end else if (dim_go) begin
      dir_q <= cmd_up;
    end
  end
  property p_no_dim_blocked;
    blocked && $past(blocked) && $past(blocked, 2) |-> !(cmd_valid && !cmd_switch);
  endproperty
  a_no_dim_blocked: assert property (p_no_dim_blocked) else $error("dim command while blocked");
  property p_stop_dir;
    dim_stop |-> cmd_up == dir_q;
  endproperty
  a_stop_dir: assert property (p_stop_dir) else $error("stop direction differs");
  property p_stop_debounced;
    dim_stop |-> low_q >= 24'(LOW_MIN);
  endproperty
  a_stop_debounced: assert property (p_stop_debounced) else $error("stop before release settled");
  property p_dclick_quiet;
    dclick_pulse |-> !cmd_valid ##1 !dclick_pulse;
  endproperty
  a_dclick_quiet: assert property (p_dclick_quiet) else $error("double click not a lone pulse");
  property p_toggle_follows;
    cmd_valid && cmd_switch |-> ##[0:1] toggle_state == cmd_on;
  endproperty
  a_toggle_follows: assert property (p_toggle_follows) else $error("toggle state lags switch");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read response repeated");
  property p_r_err_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_r_err_zero: assert property (p_r_err_zero) else $error("error read carries data");
endmodule
bind pushbutton_dimming_input dim_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .button_in(button_in), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .cmd_valid(cmd_valid), .cmd_switch(cmd_switch),
  .cmd_on(cmd_on), .cmd_up(cmd_up), .cmd_step(cmd_step), .dclick_pulse(dclick_pulse),
  .toggle_state(toggle_state), .blocked(blocked));
`default_nettype wire

/* tb/tb_pushbutton_dimming_input.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pushbutton_dimming_input;
  import dim_input_pkg::*;
  localparam int MS = 5;
  typedef struct packed {
    logic en, inv;
    logic [1:0] bs, bc;
    logic sn, blk, cn;
    logic [5:0] sc, cc;
  } blk_s;
  logic aclk = 1'b0, aresetn = 1'b0, press = 1'b0, bus_restored = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_switch, cmd_on, cmd_up;
  logic dclick_pulse, toggle_state, blocked, button_in;
  logic [1:0] bresp, rresp;
  logic [2:0] cmd_step;
  logic [15:0] n_cmd, n0;
  logic [5:0] last_cmd;
  logic [5:0] sh [4] = '{6'h30, 6'h20, 6'h20, 6'h30};
  blk_s bt [5] = '{'{1, 0, 2, 2, 1, 1, 1, 6'h30, 6'h20}, '{1, 0, 1, 0, 0, 1, 0, 6'h0, 6'h0},
    '{1, 0, 0, 1, 0, 0, 0, 6'h0, 6'h0}, '{0, 0, 2, 2, 0, 0, 0, 6'h0, 6'h0},
    '{1, 1, 3, 1, 1, 1, 1, 6'h20, 6'h30}};
  blk_s b;
  logic [31:0] c;
  int num_errors = 0, n_tests = 0, n_dc = 0, d0;

  pushbutton_dimming_input #(.MS_CYCLES(MS)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .button_in(button_in), .bus_restored(bus_restored),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_valid(cmd_valid),
    .cmd_switch(cmd_switch), .cmd_on(cmd_on), .cmd_up(cmd_up), .cmd_step(cmd_step),
    .dclick_pulse(dclick_pulse), .toggle_state(toggle_state), .blocked(blocked));
  dim_partner u_far (.aclk(aclk), .press(press), .button_in(button_in), .cmd_valid(cmd_valid),
    .cmd_switch(cmd_switch), .cmd_on(cmd_on), .cmd_up(cmd_up), .cmd_step(cmd_step),
    .n_cmd(n_cmd), .last_cmd(last_cmd));

  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) if (dclick_pulse) n_dc <= n_dc + 1;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    num_errors++;
    $display("Error at %0t: bus timeout", $time);
    summarize();
  endtask
  task automatic wms(input int n);
    repeat (n * MS) @(posedge aclk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int i;
    i = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      i++;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb && i < 200);
    bready <= 1'b0;
    if (!tb) tmo();
    chk(32'(r), 32'(er));
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    int i;
    i = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      i++;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr && i < 200);
    rready <= 1'b0;
    if (!tr) tmo();
    chk(d, ed);
    chk(32'(r), 32'(er));
    @(posedge aclk);
  endtask
  task automatic click(input int hold_ms, input int gap_ms);
    press <= 1'b1;
    wms(hold_ms);
    press <= 1'b0;
    wms(gap_ms);
  endtask
  task automatic hold(input logic [5:0] dim, input logic [5:0] stp);
    click(400, 0);
    chk(32'(last_cmd), 32'(dim));
    wms(100);
    chk(32'(last_cmd), 32'(stp));
  endtask
  task automatic rst(input logic [3:0] code, input int pre_ms, input logic [5:0] exp);
    axw(OFF_CTRL, 32'h5 | (32'(code) << F_RST), RESP_OKAY);
    n0 = n_cmd;
    bus_restored <= 1'b1;
    @(posedge aclk);
    bus_restored <= 1'b0;
    wms(pre_ms);
    if (pre_ms > 0) chk(32'(n_cmd - n0), 32'h0);
    wms(200);
    chk(32'(n_cmd - n0), 32'h1);
    chk(32'(last_cmd), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFF_CTRL, CTRL_RESET, RESP_OKAY);
    axr(OFF_BLOCK, 32'h0, RESP_OKAY);
    axw(4'h2, 32'h5, RESP_SLVERR);
    axr(4'h2, 32'h0, RESP_SLVERR);
    axr(OFF_CTRL, CTRL_RESET, RESP_OKAY);
    $display("registers done");
    n0 = n_cmd;
    axw(OFF_CTRL, 32'h4 | (32'h1 << F_RST), RESP_OKAY);
    bus_restored <= 1'b1;
    @(posedge aclk);
    bus_restored <= 1'b0;
    click(100, 100);
    axw(OFF_CTRL, 32'h3, RESP_OKAY);
    click(400, 100);
    chk(32'(n_cmd - n0), 32'h0);
    axw(OFF_CTRL, 32'h5, RESP_OKAY);
    click(100, 100);
    chk(32'(last_cmd), 32'h30);
    chk(32'(toggle_state), 32'h1);
    axr(OFF_LASTCMD, 32'h3, RESP_OKAY);
    click(200, 100);
    chk(32'(last_cmd), 32'h20);
    hold(6'h09, 6'h08);
    hold(6'h01, 6'h00);
    $display("one button done");
    for (int v = 1; v <= 4; v++) begin
      axw(OFF_CTRL, 32'h5 | (32'(v) << F_VAR) | (32'(v) << F_INC), RESP_OKAY);
      click(100, 100);
      chk(32'(last_cmd), 32'(sh[v-1]));
      hold({2'b00, 1'(v < 3), 3'(v + 1)}, {2'b00, 1'(v < 3), 3'h0});
    end
    $display("variants done");
    axw(OFF_CTRL, 32'h5 | (32'h1 << F_DCEN), RESP_OKAY);
    n0 = n_cmd;
    d0 = n_dc;
    click(100, 100);
    click(100, 400);
    chk(32'(n_dc - d0), 32'h1);
    chk(32'(n_cmd - n0), 32'h0);
    click(100, 400);
    click(100, 600);
    chk(32'(n_cmd - n0), 32'h2);
    chk(32'(last_cmd), 32'h30);
    $display("double click done");
    for (int k = 0; k < 5; k++) begin
      b = bt[k];
      c = 32'h5 | (32'(b.inv) << F_BLKINV) | (32'(b.bs) << F_BSET) | (32'(b.bc) << F_BCAN);
      axw(OFF_CTRL, c, RESP_OKAY);
      axw(OFF_BLOCK, {31'h0, b.inv}, RESP_OKAY);
      axw(OFF_CTRL, c | (32'(b.en) << F_BLKEN), RESP_OKAY);
      n0 = n_cmd;
      axw(OFF_BLOCK, {31'h0, !b.inv}, RESP_OKAY);
      wms(2);
      chk(32'(blocked), 32'(b.blk));
      chk(32'(n_cmd - n0), 32'(b.sn));
      if (b.sn) chk(32'(last_cmd), 32'(b.sc));
      n0 = n_cmd;
      if (b.blk) click(400, 100);
      chk(32'(n_cmd - n0), 32'h0);
      axw(OFF_BLOCK, {31'h0, b.inv}, RESP_OKAY);
      wms(2);
      chk(32'(blocked), 32'h0);
      chk(32'(n_cmd - n0), 32'(b.cn));
      if (b.cn) chk(32'(last_cmd), 32'(b.cc));
    end
    $display("block done");
    rst(4'h1, 0, 6'h30);
    rst(4'h2, 0, 6'h20);
    rst(4'h3, 4900, 6'h30);
    $display("restore done");
    summarize();
  end
endmodule
`default_nettype wire
